// [verilog/pwr_gate_pkg.sv]
// Package for the power gating and radio pin control block.
// Assumes both ends import it; offsets are byte addresses on the register port.
package pwr_gate_pkg;
  localparam logic [8:0] PERIPH_GATE_A_OFS = 9'h064;
  localparam logic [8:0] PERIPH_GATE_B_OFS = 9'h065;
  localparam logic [8:0] SRAM_GATE_OFS     = 9'h063;
  localparam logic [8:0] RADIO_PINS_OFS    = 9'h066;
  localparam logic [8:0] SRAM1_RET_OFS     = 9'h134;
  localparam logic [8:0] SRAM0_RET_OFS     = 9'h135;
  localparam logic [8:0] SLEEP_MODE_OFS    = 9'h067;
  localparam logic [8:0] STATUS_OFS        = 9'h068;
  localparam int CONV_GATE_BIT    = 0;
  localparam int SER0_GATE_BIT    = 1;
  localparam int SYNC_GATE_BIT    = 2;
  localparam int TIMER1_GATE_BIT  = 3;
  localparam int AMP_REDUCE_BIT   = 4;
  localparam int TIMER0_GATE_BIT  = 5;
  localparam int SER1_GATE_BIT    = 0;
  localparam int TIMER3_GATE_BIT  = 3;
  localparam int TIMER4_GATE_BIT  = 4;
  localparam int TIMER5_GATE_BIT  = 5;
  localparam int RADIO_GATE_BIT   = 6;
  localparam int RADIO_RESET_BIT  = 0;
  localparam int SLEEP_TRIG_BIT   = 1;
  localparam int SUPPLY_OK_BIT    = 5;
  localparam int RET_EN_BIT       = 4;
  localparam logic [7:0] GATE_B_MASK   = 8'h7f;
  localparam logic [7:0] SRAM_MASK     = 8'h0f;
  localparam logic [7:0] RET_RW_MASK   = 8'h1f;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [3:0] RET_CAL_DEF   = 4'h0;
  localparam int SRAM_BLOCKS       = 4;
  localparam int RADIO_RST_CYCLES  = 4;
  localparam int SUPPLY_UP_CYCLES  = 8;
  typedef enum logic [2:0] {
    RADIO_IDLE   = 3'b000,
    RADIO_SLEEP  = 3'b001,
    RADIO_LOCKED = 3'b011,
    RADIO_TX     = 3'b010,
    RADIO_LISTEN = 3'b110,
    RADIO_AACK   = 3'b111,
    RADIO_ARET   = 3'b101,
    RADIO_HOLD   = 3'b100
  } radio_state_t;
endpackage

// [verilog/pwr_gate_if.sv]
// Interface joining the gating register end and the gated peripheral end.
// Assumes one clock and reset shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface pwr_gate_if;
  logic [7:0] gate_a;
  logic [6:0] gate_b;
  logic [3:0] sram_gate;
  logic [3:0] sram_ret_en;
  logic       deep_sleep;
  logic       mode_down_save;
  logic       trig_rise;
  logic       trig_fall;
  logic       radio_reset;
  logic       radio_reset_busy;
  logic       conv_enabled;
  logic [3:0] sram_supply_ok;
  modport ctrl (
    output gate_a, gate_b, sram_gate, sram_ret_en, deep_sleep, mode_down_save,
    output trig_rise, trig_fall, radio_reset,
    input  radio_reset_busy, conv_enabled, sram_supply_ok
  );
  modport periph (
    input  gate_a, gate_b, sram_gate, sram_ret_en, deep_sleep, mode_down_save,
    input  trig_rise, trig_fall, radio_reset,
    output radio_reset_busy, conv_enabled, sram_supply_ok
  );
endinterface
`default_nettype wire

// [verilog/pwr_gate_ctrl.sv]
// Register end of the power gating block: gating, retention and radio pin registers.
// Assumes a single-cycle register port with read data one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module pwr_gate_ctrl
  import pwr_gate_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [8:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [3:0] ret_cal_i,
  output logic      [7:0] rdata_o,
  pwr_gate_if.ctrl        link
);
  // The request to the far end stands only until it answers with busy; the bit
  // that software reads stays up until busy drops again.
  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_REQ  = 2'b01,
    RST_WAIT = 2'b11
  } rst_state_t;

  logic [7:0] gate_a_q;
  logic [6:0] gate_b_q;
  logic [3:0] sram_gate_q;
  logic [4:0] ret0_q;
  logic [4:0] ret1_q;
  logic [3:0] ret_en_hi_q;
  logic [1:0] mode_q;
  logic       trig_q;
  logic       trig_prev_q;
  rst_state_t rst_st_q;
  logic       rise_q;
  logic       fall_q;
  logic       cal_load_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Timer, serial, converter and amplifier bits act straight from this register.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_a_q <= REG_RESET;
    end else if (wr_i && addr_i == PERIPH_GATE_A_OFS) begin
      gate_a_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_b_q <= 7'h00;
    end else if (wr_i && addr_i == PERIPH_GATE_B_OFS) begin
      gate_b_q <= wdata_i[6:0] & GATE_B_MASK[6:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sram_gate_q <= 4'h0;
    end else if (wr_i && addr_i == SRAM_GATE_OFS) begin
      sram_gate_q <= wdata_i[3:0];
    end
  end

  // Calibration bits cannot take the strap under async reset; they are caught
  // on the first clock after release.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cal_load_q <= 1'b1;
      ret0_q     <= {1'b0, RET_CAL_DEF};
      ret1_q     <= {1'b0, RET_CAL_DEF};
    end else begin
      cal_load_q <= 1'b0;
      if (cal_load_q) begin
        ret0_q[3:0] <= ret_cal_i;
        ret1_q[3:0] <= ret_cal_i;
      end else if (wr_i && addr_i == SRAM0_RET_OFS) begin
        ret0_q <= wdata_i[4:0];
      end else if (wr_i && addr_i == SRAM1_RET_OFS) begin
        ret1_q <= wdata_i[4:0];
      end
    end
  end

  // Blocks 2 and 3 keep their retention enables in our sleep mode register.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ret_en_hi_q <= 4'h0;
      mode_q      <= 2'b00;
    end else if (wr_i && addr_i == SLEEP_MODE_OFS) begin
      mode_q      <= wdata_i[1:0];
      ret_en_hi_q <= wdata_i[7:4];
    end
  end

  // The request drops as soon as the far end shows busy, so a held request can
  // never restart the far end's reset count; a reset bit written during a reset is ignored.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_st_q <= RST_IDLE;
    end else begin
      case (rst_st_q)
        RST_IDLE: begin
          if (wr_i && addr_i == RADIO_PINS_OFS && wdata_i[RADIO_RESET_BIT]) begin
            rst_st_q <= RST_REQ;
          end
        end
        RST_REQ: begin
          if (link.radio_reset_busy) begin
            rst_st_q <= RST_WAIT;
          end
        end
        RST_WAIT: begin
          if (!link.radio_reset_busy) begin
            rst_st_q <= RST_IDLE;
          end
        end
        default: begin
          rst_st_q <= RST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_q <= 1'b0;
    end else if (wr_i && addr_i == RADIO_PINS_OFS) begin
      trig_q <= wdata_i[SLEEP_TRIG_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_prev_q <= 1'b0;
      rise_q      <= 1'b0;
      fall_q      <= 1'b0;
    end else begin
      trig_prev_q <= trig_q;
      rise_q      <= trig_q && !trig_prev_q;
      fall_q      <= !trig_q && trig_prev_q;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (addr_i == PERIPH_GATE_A_OFS) begin
      rdata_d = gate_a_q;
    end else if (addr_i == PERIPH_GATE_B_OFS) begin
      rdata_d = {1'b0, gate_b_q};
    end else if (addr_i == SRAM_GATE_OFS) begin
      rdata_d = {4'h0, sram_gate_q};
    end else if (addr_i == RADIO_PINS_OFS) begin
      rdata_d = {6'h00, trig_q, rst_st_q != RST_IDLE};
    end else if (addr_i == SRAM0_RET_OFS) begin
      rdata_d = {2'b00, link.sram_supply_ok[0], ret0_q};
    end else if (addr_i == SRAM1_RET_OFS) begin
      rdata_d = {2'b00, link.sram_supply_ok[1], ret1_q};
    end else if (addr_i == SLEEP_MODE_OFS) begin
      rdata_d = {ret_en_hi_q, 2'b00, mode_q};
    end else if (addr_i == STATUS_OFS) begin
      rdata_d = {3'b000, link.conv_enabled, link.sram_supply_ok};
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o             = rdata_q;
  assign link.gate_a         = gate_a_q;
  assign link.gate_b         = gate_b_q;
  assign link.sram_gate      = sram_gate_q;
  assign link.sram_ret_en    = {ret_en_hi_q[3:2], ret1_q[RET_EN_BIT], ret0_q[RET_EN_BIT]};
  assign link.deep_sleep     = mode_q[1];
  assign link.mode_down_save = mode_q[1];
  assign link.trig_rise      = rise_q;
  assign link.trig_fall      = fall_q;
  assign link.radio_reset    = (rst_st_q == RST_REQ);
endmodule
`default_nettype wire

// [verilog/pwr_gate_periph.sv]
// Gated peripheral end: clock enables, SRAM switches and the radio state machine.
// Assumes the register end drives the gate and trigger signals on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pwr_gate_periph
  import pwr_gate_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       conv_enable_i,
  input  wire logic       comp_mux_req_i,
  input  wire logic       radio_lock_i,
  input  wire logic       radio_listen_i,
  input  wire logic       radio_tx_done_i,
  pwr_gate_if.periph      link,
  output logic      [4:0] timer_run_o,
  output logic            sync_serial_clk_en_o,
  output logic      [1:0] serial_clk_en_o,
  output logic            amp_low_bias_o,
  output logic            conv_power_o,
  output logic            comp_mux_grant_o,
  output logic            radio_supply_o,
  output logic            power_chain_o,
  output logic      [3:0] sram_supply_o,
  output logic      [3:0] sram_retain_o,
  output logic      [2:0] radio_state_o
);
  radio_state_t st_q;
  radio_state_t prev_q;
  logic [2:0] rst_cnt_q;
  logic [3:0] up_cnt_q [SRAM_BLOCKS];
  logic [3:0] ok_q;
  logic       conv_en_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_run_o          <= 5'h00;
      sync_serial_clk_en_o <= 1'b0;
      serial_clk_en_o      <= 2'b00;
      amp_low_bias_o       <= 1'b0;
      conv_power_o         <= 1'b0;
      comp_mux_grant_o     <= 1'b0;
      radio_supply_o       <= 1'b0;
      power_chain_o        <= 1'b0;
      conv_en_q            <= 1'b0;
    end else begin
      timer_run_o <= {~link.gate_b[TIMER5_GATE_BIT], ~link.gate_b[TIMER4_GATE_BIT],
                      ~link.gate_b[TIMER3_GATE_BIT], ~link.gate_a[TIMER1_GATE_BIT],
                      ~link.gate_a[TIMER0_GATE_BIT]};
      sync_serial_clk_en_o <= ~link.gate_a[SYNC_GATE_BIT];
      serial_clk_en_o <= {~link.gate_b[SER1_GATE_BIT], ~link.gate_a[SER0_GATE_BIT]};
      amp_low_bias_o <= link.gate_a[AMP_REDUCE_BIT];
      conv_power_o <= ~link.gate_a[CONV_GATE_BIT];
      comp_mux_grant_o <= comp_mux_req_i && !link.gate_a[CONV_GATE_BIT];
      conv_en_q <= conv_enable_i && !link.gate_a[CONV_GATE_BIT];
      radio_supply_o <= ~link.gate_b[RADIO_GATE_BIT];
      power_chain_o <= !(link.gate_b[RADIO_GATE_BIT] && link.mode_down_save);
    end
  end

  // A block reports ready only after its switch has been on for a settling count.
  for (genvar i = 0; i < SRAM_BLOCKS; i++) begin : g_sram
    logic on_w;
    assign on_w = !link.sram_gate[i] && !(link.deep_sleep && !link.sram_ret_en[i]);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        up_cnt_q[i]      <= 4'h0;
        ok_q[i]          <= 1'b0;
        sram_supply_o[i] <= 1'b0;
        sram_retain_o[i] <= 1'b0;
      end else begin
        sram_supply_o[i] <= on_w && !link.deep_sleep;
        sram_retain_o[i] <= on_w && link.deep_sleep;
        if (!on_w || link.deep_sleep) begin
          up_cnt_q[i] <= 4'h0;
          ok_q[i]     <= 1'b0;
        end else if (up_cnt_q[i] == 4'(SUPPLY_UP_CYCLES)) begin
          ok_q[i] <= 1'b1;
        end else begin
          up_cnt_q[i] <= up_cnt_q[i] + 4'h1;
        end
      end
    end
  end

  // The reset holds the machine for a fixed count; the register end waits on busy.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q      <= RADIO_IDLE;
      prev_q    <= RADIO_IDLE;
      rst_cnt_q <= 3'h0;
    end else if (link.radio_reset || rst_cnt_q != 3'h0) begin
      st_q   <= RADIO_IDLE;
      prev_q <= RADIO_IDLE;
      if (link.radio_reset && rst_cnt_q == 3'h0) begin
        rst_cnt_q <= 3'(RADIO_RST_CYCLES);
      end else begin
        rst_cnt_q <= rst_cnt_q - 3'h1;
      end
    end else begin
      case (st_q)
        RADIO_IDLE: begin
          if (link.trig_rise) begin
            st_q <= RADIO_SLEEP;
          end else if (radio_lock_i) begin
            st_q <= RADIO_LOCKED;
          end else if (radio_listen_i) begin
            st_q <= RADIO_LISTEN;
          end
        end
        RADIO_SLEEP: begin
          if (link.trig_fall) begin
            st_q <= RADIO_IDLE;
          end
        end
        RADIO_LOCKED, RADIO_ARET: begin
          if (link.trig_rise) begin
            prev_q <= st_q;
            st_q   <= RADIO_TX;
          end
        end
        RADIO_TX: begin
          if (radio_tx_done_i) begin
            st_q <= prev_q;
          end
        end
        RADIO_LISTEN, RADIO_AACK: begin
          if (link.trig_rise) begin
            prev_q <= st_q;
            st_q   <= RADIO_HOLD;
          end
        end
        RADIO_HOLD: begin
          if (link.trig_fall) begin
            st_q <= prev_q;
          end
        end
        default: st_q <= RADIO_IDLE;
      endcase
    end
  end

  assign radio_state_o          = st_q;
  assign link.radio_reset_busy  = rst_cnt_q != 3'h0;
  assign link.conv_enabled      = conv_en_q;
  assign link.sram_supply_ok    = ok_q;
endmodule
`default_nettype wire

// [bench/pwr_gate_asserts.sv]
// Checker for the link between the register end and the peripheral end.
// Assumes one clock and an active-low reset shared by both ends.
`timescale 1ns/1ps
`default_nettype none
module pwr_gate_checker (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic [3:0] sram_gate,
  input wire logic       deep_sleep,
  input wire logic       trig_rise,
  input wire logic       trig_fall,
  input wire logic       radio_reset,
  input wire logic       radio_reset_busy,
  input wire logic [3:0] sram_supply_ok
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence rst_req;
    $rose(radio_reset);
  endsequence
  sequence ram1_on;
    $fell(sram_gate[1]) && !deep_sleep;
  endsequence
  a_edge_excl: assert property (!(trig_rise && trig_fall))
    else $error("rise and fall pulses together");
  a_rise_pulse: assert property (trig_rise |=> !trig_rise)
    else $error("rise pulse longer than one cycle");
  a_fall_pulse: assert property (trig_fall |=> !trig_fall)
    else $error("fall pulse longer than one cycle");
  a_reset_busy: assert property (rst_req |-> ##[0:2] radio_reset_busy)
    else $error("radio reset not taken by far end");
  a_reset_clear: assert property (rst_req |-> ##[1:16] !radio_reset)
    else $error("radio reset bit did not clear");
  a_reset_quiet: assert property (radio_reset |-> !trig_rise)
    else $error("trigger edge during radio reset");
  a_ram_off: assert property (sram_gate[3] [*4] |-> !sram_supply_ok[3])
    else $error("gated block still reports supply");
  a_ram_up: assert property (ram1_on |-> !sram_supply_ok[1] [*4] ##[1:12] sram_supply_ok[1])
    else $error("supply ok timing wrong");
endmodule
`default_nettype wire

// [bench/power_gating_radio_ctrl_bench.sv]
// Bench joining both ends of the power gating block through the interface.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module power_gating_radio_ctrl_bench;
  import pwr_gate_pkg::*;
  logic       clk_i, rst_b_i, wr_i, rd_i;
  logic [8:0] addr_i;
  logic [7:0] wdata_i, rdata_o, a, b, d, v;
  logic [3:0] ret_cal_i, ram_sup, ram_ret;
  logic       conv_en, mux_req, lock, listen, tx_done;
  logic       sync_en, amp_low, conv_pwr, mux_gnt, radio_sup, chain;
  logic [4:0] timer_run;
  logic [1:0] ser_en;
  logic [2:0] state;
  int         mismatches, n_checks;
  pwr_gate_if link ();
  pwr_gate_ctrl i_pwr_gate_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .ret_cal_i(ret_cal_i),
    .rdata_o(rdata_o), .link(link));
  pwr_gate_periph i_pwr_gate_periph (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .conv_enable_i(conv_en), .comp_mux_req_i(mux_req), .radio_lock_i(lock),
    .radio_listen_i(listen), .radio_tx_done_i(tx_done), .link(link),
    .timer_run_o(timer_run), .sync_serial_clk_en_o(sync_en), .serial_clk_en_o(ser_en),
    .amp_low_bias_o(amp_low), .conv_power_o(conv_pwr), .comp_mux_grant_o(mux_gnt),
    .radio_supply_o(radio_sup), .power_chain_o(chain), .sram_supply_o(ram_sup),
    .sram_retain_o(ram_ret), .radio_state_o(state));
  pwr_gate_checker i_pwr_gate_checker (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sram_gate(link.sram_gate), .deep_sleep(link.deep_sleep),
    .trig_rise(link.trig_rise), .trig_fall(link.trig_fall),
    .radio_reset(link.radio_reset), .radio_reset_busy(link.radio_reset_busy),
    .sram_supply_ok(link.sram_supply_ok));

  function automatic logic [4:0] run_exp(input logic [7:0] ga, input logic [7:0] gb);
    return ~{gb[5], gb[4], gb[3], ga[3], ga[5]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [8:0] ad, input logic [7:0] dt);
    @(posedge clk_i);
    addr_i <= ad;
    wdata_i <= dt;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] ad);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic wait_st(input radio_state_t s);
    for (int i = 0; i < 20 && state !== s; i++) tick(1);
    chk(8'(state), 8'(s));
  endtask
  task automatic radio_rst();
    wr(RADIO_PINS_OFS, 8'h01);
    rd(RADIO_PINS_OFS);
    chk(v, 8'h01);
    wait_st(RADIO_IDLE);
    tick(10);
    rd(RADIO_PINS_OFS);
    chk(v, 8'h00);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // The whole run is a few hundred cycles; this leaves wide margin.
  initial begin
    #200us;
    mismatches++;
    end_sim();
  end
  initial begin
    rst_b_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = '0; wdata_i = '0;
    ret_cal_i = 4'h9; conv_en = 1'b0; mux_req = 1'b1;
    lock = 1'b0; listen = 1'b0; tx_done = 1'b0;
    void'($urandom(32'h3f9b1f3d));
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    tick(12);
    rd(SRAM_GATE_OFS); chk(v, REG_RESET);
    rd(PERIPH_GATE_B_OFS); chk(v, REG_RESET);
    rd(SRAM0_RET_OFS); chk(v, 8'h29);
    rd(SRAM1_RET_OFS); chk(v, 8'h29);
    $display("test reset values done");
    // Converter enable is held low throughout, so gating it is always legal.
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 8'hff : 8'($urandom);
      b = (k == 0) ? 8'hff : 8'($urandom);
      wr(PERIPH_GATE_A_OFS, a);
      wr(PERIPH_GATE_B_OFS, b);
      tick(3);
      chk(8'(timer_run), 8'(run_exp(a, b)));
      chk(8'({ser_en, sync_en}), 8'(3'(~{b[0], a[1], a[2]})));
      chk(8'(amp_low), 8'(a[4]));
      chk(8'(conv_pwr), 8'(!a[0]));
      chk(8'(mux_gnt), 8'(!a[0]));
      chk(8'(radio_sup), 8'(!b[6]));
      rd(PERIPH_GATE_A_OFS); chk(v, a);
      rd(PERIPH_GATE_B_OFS); chk(v, b & GATE_B_MASK);
    end
    $display("test peripheral gates done");
    wr(PERIPH_GATE_A_OFS, 8'h00);
    @(posedge clk_i) conv_en <= 1'b1;
    tick(2);
    rd(STATUS_OFS);
    chk(8'(v[4]), 8'h01);
    @(posedge clk_i) conv_en <= 1'b0;
    wr(SRAM0_RET_OFS, 8'h19);
    wr(SLEEP_MODE_OFS, 8'h02);
    wr(PERIPH_GATE_B_OFS, 8'h40);
    tick(3);
    chk(8'(chain), 8'h00);
    chk(8'(ram_ret[1:0]), 8'h01);
    chk(8'(ram_sup[1]), 8'h00);
    wr(PERIPH_GATE_B_OFS, 8'h00);
    tick(3);
    chk(8'(chain), 8'h01);
    wr(SLEEP_MODE_OFS, 8'h00);
    $display("test deep sleep done");
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hff : 8'($urandom);
      wr(SRAM_GATE_OFS, d);
      tick(14);
      chk(8'(ram_sup), 8'(4'(~d[3:0])));
      rd(SRAM_GATE_OFS); chk(v, d & SRAM_MASK);
      rd(STATUS_OFS); chk(8'(v[3:0]), 8'(4'(~d[3:0])));
    end
    $display("test sram gates done");
    wr(RADIO_PINS_OFS, 8'h02); wait_st(RADIO_SLEEP);
    wr(RADIO_PINS_OFS, 8'h00); wait_st(RADIO_IDLE);
    @(posedge clk_i) lock <= 1'b1;
    wait_st(RADIO_LOCKED);
    wr(RADIO_PINS_OFS, 8'h02); wait_st(RADIO_TX);
    wr(RADIO_PINS_OFS, 8'h00); tick(4);
    chk(8'(state), 8'(RADIO_TX));
    @(posedge clk_i) tx_done <= 1'b1;
    @(posedge clk_i) tx_done <= 1'b0;
    wait_st(RADIO_LOCKED);
    @(posedge clk_i) lock <= 1'b0;
    radio_rst();
    @(posedge clk_i) listen <= 1'b1;
    wait_st(RADIO_LISTEN);
    wr(RADIO_PINS_OFS, 8'h02); wait_st(RADIO_HOLD);
    wr(RADIO_PINS_OFS, 8'h00); wait_st(RADIO_LISTEN);
    @(posedge clk_i) listen <= 1'b0;
    radio_rst();
    $display("test radio pins done");
    end_sim();
  end
endmodule
`default_nettype wire
